/* File: shared/ioc_consts.vh */
/*
 * Constants for the interlock override control group: register offsets,
 * field positions, reset values and the parameter timeout.
 * Assumes a 25 MHz clock; includers take these as plain `define macros.
 */
`ifndef IOC_CONSTS_VH
`define IOC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (16-bit word addresses)
// ----------------------------------------------------------------
`define IOC_ADDR_EXECUTE 16'hAC40
`define IOC_ADDR_PASS_HI 16'hAC41
`define IOC_ADDR_PASS_LO 16'hAC42
`define IOC_ADDR_RSVD 16'hAC43
`define IOC_ADDR_SELECT 16'hAC44
`define IOC_ADDR_OVR_STATE 16'hAC45
`define IOC_ADDR_FORCE 16'hAC46
`define IOC_ADDR_STATUS 16'hAC47

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define IOC_EXEC_VALUE 16'h0001
`define IOC_SEL_BIT 0
`define IOC_STATE_BIT 0
`define IOC_FORCE_BIT 0
`define IOC_WORD_RESET 16'h0000
`define IOC_PASS_HI_DEFAULT 16'h0000
`define IOC_PASS_LO_DEFAULT 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOC_CLK_HZ 25000000
`define IOC_TIMEOUT_S 15
`define IOC_TIMEOUT_CYC (`IOC_TIMEOUT_S * `IOC_CLK_HZ)

`endif

/* File: hdl/ioc_timeout.v */
/*
 * Parameter timeout counter: counts while armed, pulses expiry once
 * the programmed count has elapsed, restarts on every restart pulse.
 * Assumes restart and arm come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.vh"

module ioc_timeout #(
	parameter [31:0] LIMIT = `IOC_TIMEOUT_CYC
) (
	input wire clk_in,
	input wire nrst_in,
	input wire arm_in,
	input wire restart_in,
	output reg expired_out
);

reg [31:0] count_r;

always @(posedge clk_in)
begin
	if (!nrst_in)
	begin
		count_r <= 32'h00000000;
		expired_out <= 1'b0;
	end
	else if (restart_in || !arm_in)
	begin
		count_r <= 32'h00000000;
		expired_out <= 1'b0;
	end
	else
	begin
		expired_out <= (count_r == LIMIT - 32'h00000001);
		if (count_r != LIMIT - 32'h00000001)
			count_r <= count_r + 32'h00000001;
		else
			count_r <= 32'h00000000;
	end
end

endmodule // ioc_timeout

`default_nettype wire

/* File: hdl/ioc_control_group.v */
/*
 * Interlock override control group: password-gated select-before-operate
 * register bank driving the interlocking switch override and force level.
 * Assumes a protocol front end on the same clock presents decoded
 * single-word register writes and reads (address, data, strobe); framing
 * and function codes are handled outside.
 */
// Behaviour
// - Only the value 1 written to execute performs the action; other values do nothing.
// - Select word bit 0 picks the interlock switch override; other bits reserved.
// - State bit 0 set applies the override; cleared inhibits it.
// - When selected with state bit 0 set, force bit 0 drives the controlled point high or low.
// - This group touches only the interlock switch, nothing else.
// - No execute within 15 s of the last parameter write clears the staged words; applied outputs hold.
// - Correct high and low password words gate the control action.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.vh"

module ioc_control_group #(
	parameter [31:0] TIMEOUT_CYC = `IOC_TIMEOUT_CYC,
	parameter [15:0] PASS_HI = `IOC_PASS_HI_DEFAULT,
	parameter [15:0] PASS_LO = `IOC_PASS_LO_DEFAULT
) (
	input wire clk_in,
	input wire nrst_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [15:0] addr_in,
	input wire [15:0] wdata_in,
	output reg [15:0] rdata_out,
	output reg rd_valid_out,
	output reg exec_done_out,
	output reg exec_reject_out,
	output reg override_en_out,
	output reg force_level_out,
	output reg cleared_out
);

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [15:0] pass_hi_r;
reg [15:0] pass_lo_r;
reg select_r;
reg state_r;
reg force_r;
reg pending_r;
reg [15:0] rdata_nxt;
wire expired;

// ----------------------------------------------------------------
// Decode and packing helpers
// ----------------------------------------------------------------
// Staging words; a write to any of them re-arms the timeout
function is_stage_addr;
	input [15:0] addr;
	begin
		case (addr)
			`IOC_ADDR_PASS_HI: is_stage_addr = 1'b1;
			`IOC_ADDR_PASS_LO: is_stage_addr = 1'b1;
			`IOC_ADDR_SELECT: is_stage_addr = 1'b1;
			`IOC_ADDR_OVR_STATE: is_stage_addr = 1'b1;
			`IOC_ADDR_FORCE: is_stage_addr = 1'b1;
			default: is_stage_addr = 1'b0;
		endcase
	end
endfunction

// Both halves must match, so a half-written password never unlocks
function pass_match;
	input [15:0] hi;
	input [15:0] lo;
	begin
		pass_match = (hi == PASS_HI) && (lo == PASS_LO);
	end
endfunction

// One-bit registers read back with every reserved bit as zero
function [15:0] bit_word;
	input b;
	begin
		bit_word = {15'h0000, b};
	end
endfunction

// Status packs the applied outputs so a host can confirm an execute
function [15:0] status_word;
	input pend;
	input lvl;
	input ovr;
	begin
		status_word = {13'h0000, pend, lvl, ovr};
	end
endfunction

wire wr_exec = wr_en_in && (addr_in == `IOC_ADDR_EXECUTE);
wire wr_param = wr_en_in && is_stage_addr(addr_in);
wire exec_one = wr_exec && (wdata_in == `IOC_EXEC_VALUE);
wire pass_ok = pass_match(pass_hi_r, pass_lo_r);
// Select must be set too, or the execute is refused
wire exec_ok = pass_ok && select_r;

// ----------------------------------------------------------------
// Timeout after parameter writes
// ----------------------------------------------------------------
ioc_timeout #(
	.LIMIT(TIMEOUT_CYC)
) u_timeout (
	.clk_in(clk_in),
	.nrst_in(nrst_in),
	.arm_in(pending_r),
	.restart_in(wr_param),
	.expired_out(expired)
);

// ----------------------------------------------------------------
// Write side and control action
// ----------------------------------------------------------------
always @(posedge clk_in)
begin
	if (!nrst_in)
	begin
		pass_hi_r <= `IOC_WORD_RESET;
		pass_lo_r <= `IOC_WORD_RESET;
		select_r <= 1'b0;
		state_r <= 1'b0;
		force_r <= 1'b0;
		pending_r <= 1'b0;
		override_en_out <= 1'b0;
		force_level_out <= 1'b0;
		exec_done_out <= 1'b0;
		exec_reject_out <= 1'b0;
		cleared_out <= 1'b0;
	end
	else
	begin
		exec_done_out <= 1'b0;
		exec_reject_out <= 1'b0;
		cleared_out <= 1'b0;
		// A staging write in the expiry cycle wins and restarts the count
		if (wr_param)
		begin
			pending_r <= 1'b1;
			// Select, state and force store only bit 0; password words keep all 16 bits
			case (addr_in)
				`IOC_ADDR_PASS_HI: pass_hi_r <= wdata_in;
				`IOC_ADDR_PASS_LO: pass_lo_r <= wdata_in;
				`IOC_ADDR_SELECT: select_r <= wdata_in[`IOC_SEL_BIT];
				`IOC_ADDR_OVR_STATE: state_r <= wdata_in[`IOC_STATE_BIT];
				`IOC_ADDR_FORCE: force_r <= wdata_in[`IOC_FORCE_BIT];
				default: pending_r <= 1'b1;
			endcase
		end
		else if (exec_one)
		begin
			// Block is consumed by the execute, accepted or not
			if (exec_ok)
			begin
				override_en_out <= state_r;
				if (state_r)
					force_level_out <= force_r;
				exec_done_out <= 1'b1;
			end
			else
				exec_reject_out <= 1'b1;
			pending_r <= 1'b0;
			pass_hi_r <= `IOC_WORD_RESET;
			pass_lo_r <= `IOC_WORD_RESET;
			select_r <= 1'b0;
			state_r <= 1'b0;
			force_r <= 1'b0;
		end
		else if (expired)
		begin
			// Applied outputs hold; only the staged block is cleared
			pending_r <= 1'b0;
			pass_hi_r <= `IOC_WORD_RESET;
			pass_lo_r <= `IOC_WORD_RESET;
			select_r <= 1'b0;
			state_r <= 1'b0;
			force_r <= 1'b0;
			cleared_out <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------
// Read side
// ----------------------------------------------------------------
always @*
begin
	rdata_nxt = 16'h0000;
	case (addr_in)
		`IOC_ADDR_SELECT: rdata_nxt = bit_word(select_r);
		`IOC_ADDR_OVR_STATE: rdata_nxt = bit_word(state_r);
		`IOC_ADDR_FORCE: rdata_nxt = bit_word(force_r);
		// Passwords stay hidden; status shows the live outputs
		`IOC_ADDR_STATUS: rdata_nxt = status_word(pending_r, force_level_out, override_en_out);
		default: rdata_nxt = 16'h0000;
	endcase
end

always @(posedge clk_in)
begin
	if (!nrst_in)
	begin
		rdata_out <= 16'h0000;
		rd_valid_out <= 1'b0;
	end
	else
	begin
		rd_valid_out <= rd_en_in;
		if (rd_en_in)
			rdata_out <= rdata_nxt;
	end
end

endmodule // ioc_control_group

`default_nettype wire

/* File: dv/ioc_host.sv */
/* Host model: register writes and reads on the strobe port.
   Assumes a free clock; address and data are inverted when released. */
`timescale 1ns/1ps
`default_nettype none
module ioc_host (
	input wire logic clk_in,
	input wire logic [15:0] rdata_in,
	output logic wr_en_out = 1'h0,
	output logic rd_en_out = 1'h0,
	output logic [15:0] addr_out = 16'h0000,
	output logic [15:0] wdata_out = 16'h0000
);
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_in);
		wr_en_out = 1'h1;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		wr_en_out = 1'h0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge clk_in);
		rd_en_out = 1'h1;
		addr_out = a;
		@(negedge clk_in);
		rd_en_out = 1'h0;
		addr_out = ~a;
		d = rdata_in;
	endtask
endmodule // ioc_host
`default_nettype wire

/* File: dv/ioc_asserts.sv */
/* Port checker for the control group.
   Bound to the group; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module ioc_asserts (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic rd_valid_out,
	input wire logic exec_done_out,
	input wire logic exec_reject_out,
	input wire logic override_en_out,
	input wire logic force_level_out,
	input wire logic cleared_out,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [15:0] rdata_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_exe;
		wr_en_in && addr_in == 16'hAC40;
	endsequence
	sequence s_par;
		wr_en_in && addr_in inside {16'hAC41, 16'hAC42, 16'hAC44, 16'hAC45, 16'hAC46};
	endsequence
	property p_one; s_exe ##0 wdata_in == 16'h0001 |=> exec_done_out ^ exec_reject_out; endproperty
	a_one: assert property (p_one) else $error("execute one unanswered");
	property p_bad; s_exe ##0 wdata_in != 16'h0001 |=> !exec_done_out && !exec_reject_out; endproperty
	a_bad: assert property (p_bad) else $error("execute other acted");
	property p_ovr; !$stable(override_en_out) |-> exec_done_out; endproperty
	a_ovr: assert property (p_ovr) else $error("override moved alone");
	property p_frc; !$stable(force_level_out) |-> exec_done_out && override_en_out; endproperty
	a_frc: assert property (p_frc) else $error("force moved alone");
	property p_rej; exec_reject_out |-> $stable(override_en_out) && $stable(force_level_out); endproperty
	a_rej: assert property (p_rej) else $error("reject acted");
	property p_sel; rd_en_in && addr_in == 16'hAC44 |=> rd_valid_out && rdata_out[15:1] == 15'h0; endproperty
	a_sel: assert property (p_sel) else $error("select reserved bits");
	property p_rsv; rd_en_in && addr_in inside {16'hAC41, 16'hAC42, 16'hAC43} |=> rdata_out == 16'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("hidden word read");
	property p_clr; s_par |=> !cleared_out; endproperty
	a_clr: assert property (p_clr) else $error("clear after write");
endmodule // ioc_asserts
bind ioc_control_group ioc_asserts chk (.clk_in(clk_in), .nrst_in(nrst_in), .wr_en_in(wr_en_in),
	.rd_en_in(rd_en_in), .rd_valid_out(rd_valid_out), .exec_done_out(exec_done_out),
	.exec_reject_out(exec_reject_out), .override_en_out(override_en_out),
	.force_level_out(force_level_out), .cleared_out(cleared_out), .addr_in(addr_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out));
`default_nettype wire

/* File: dv/testbench.sv */
/* Self-checking bench for the control group.
   Assumes the host model drives every access. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin cmp_count++; if ((v) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, v); end end
module testbench;
	logic clk_in, nrst_in, wr_en, rd_en, rv, done, rej, ovr, frc, clr;
	logic [15:0] addr, wdata, rdata, d;
	int miscompares = 0, cmp_count = 0, i;
	initial
	begin
		clk_in = 1'h0;
		forever #20 clk_in = ~clk_in;
	end
	ioc_host host (.clk_in(clk_in), .rdata_in(rdata), .wr_en_out(wr_en), .rd_en_out(rd_en),
		.addr_out(addr), .wdata_out(wdata));
	ioc_control_group #(.TIMEOUT_CYC(32'h14), .PASS_HI(16'h1234), .PASS_LO(16'h5678)) dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
		.wdata_in(wdata), .rdata_out(rdata), .rd_valid_out(rv), .exec_done_out(done),
		.exec_reject_out(rej), .override_en_out(ovr), .force_level_out(frc), .cleared_out(clr));
	// Staged words as {select, state, force}
	task automatic cfg(input logic [15:0] p, input logic [2:0] v);
		host.wr(16'hAC41, p);
		host.wr(16'hAC42, 16'h5678);
		host.wr(16'hAC44, {15'h0, v[2]});
		host.wr(16'hAC45, {15'h0, v[1]});
		host.wr(16'hAC46, {15'h0, v[0]});
	endtask
	task automatic ex(input logic [15:0] v, input logic [3:0] e);
		host.wr(16'hAC40, v);
		`CHK("exec", e, {done, rej, ovr, frc})
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		nrst_in = 1'h0;
		repeat (16) @(negedge clk_in);
		`CHK("rst", 3'h0, {ovr, frc, clr})
		nrst_in = 1'h1;
		host.wr(16'hAC44, 16'hFFFF);
		host.rd(16'hAC44, d);
		`CHK("rv", 1'h1, rv)
		`CHK("sel", 16'h0001, d)
		host.wr(16'hAC46, 16'hFFFE);
		host.rd(16'hAC46, d);
		`CHK("frc", 16'h0000, d)
		host.rd(16'hAC43, d);
		`CHK("rsv", 16'h0000, d)
		cfg(16'h1235, 3'h7);
		ex(16'h0001, 4'h4);
		cfg(16'h1234, 3'h7);
		ex(16'h0002, 4'h0);
		ex(16'h0001, 4'hB);
		cfg(16'h1234, 3'h0);
		ex(16'h0001, 4'h7);
		cfg(16'h1234, 3'h6);
		ex(16'h0001, 4'hA);
		cfg(16'h1234, 3'h5);
		ex(16'h0001, 4'h8);
		cfg(16'h1234, 3'h7);
		for (i = 0; i < 40 && clr !== 1'h1; i++)
			@(negedge clk_in);
		`CHK("clr", 1'h1, clr)
		if (clr === 1'h1)
		begin
			ex(16'h0001, 4'h4);
			cfg(16'h1234, 3'h7);
			ex(16'h0001, 4'hB);
			host.rd(16'hAC47, d);
			`CHK("stat", 16'h0003, d)
		end
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
